// *** pll_clk_pkg.sv ***
// Register map, field layout and lookups of the clock block.
package pll_clk_pkg;

  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SECURITY = 8'h00;
  localparam logic [7:0] ADDR_LOOP_A = 8'h04;
  localparam logic [7:0] ADDR_LOOP_B = 8'h08;
  localparam logic [7:0] ADDR_OSC_STOP = 8'h0c;
  localparam logic [7:0] ADDR_OSC_FREQ = 8'h10;
  localparam logic [7:0] ADDR_OUT_DIV_A = 8'h14;
  localparam logic [7:0] ADDR_OUT_DIV_B = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and writable masks
  // ----------------------------------------------------------------
  localparam int IDIV_LSB = 0;
  localparam int SRC_BIT = 4;
  localparam int FRAC_LSB = 6;
  localparam int MUL_LSB = 8;
  localparam logic [15:0] LOOP_CTRL_MASK = 16'hffd3;
  localparam logic [15:0] LOOP_CTRL_RESET = 16'h1900;
  localparam logic [7:0] MUL_MIN = 8'h34;
  localparam logic [7:0] LOOP_A_MUL_MAX = 8'hb3;
  localparam logic [7:0] LOOP_B_MUL_MAX = 8'hd3;
  localparam int SEC_SYSCLK_BIT = 0;
  localparam int SEC_FASTOSC_BIT = 2;
  localparam int OSC_STOP_BIT = 0;
  localparam int OSC_FREQ_LSB = 0;
  localparam int OUT_P_LSB = 0;
  localparam int OUT_Q_LSB = 4;
  localparam int OUT_R_LSB = 8;
  localparam logic [11:0] OUT_DIV_MASK = 12'h777;
  localparam logic [11:0] OUT_DIV_RESET = 12'h000;
  localparam logic [2:0] P_CODE_MAX = 3'h4;
  localparam logic [2:0] QR_CODE_MAX = 3'h6;

  // ----------------------------------------------------------------
  // Status bits and start-up timing
  // ----------------------------------------------------------------
  localparam int ST_REFUSED = 0;
  localparam int ST_BOOTED = 1;
  localparam int ST_STOPPED = 2;
  localparam int ST_MUL_BAD_A = 3;
  localparam int ST_MUL_BAD_B = 4;
  localparam logic [2:0] STRAP_SETTLE = 3'h4;
  localparam logic [2:0] OSC_FREQ_RESET = 3'h0;

  typedef enum logic {
    BOOT_SETTLE = 1'b0,
    BOOT_RUN = 1'b1
  } boot_e;

  // Input divider code to divide ratio 1..4.
  function automatic logic [2:0] idiv_ratio(input logic [1:0] code);
    idiv_ratio = {1'b0, code} + 3'h1;
  endfunction

  // Fractional factor code to sixths: 0, 1/3, 2/3, 1/2.
  function automatic logic [2:0] frac_sixths(input logic [1:0] code);
    case (code)
      2'h1: frac_sixths = 3'h2;
      2'h2: frac_sixths = 3'h4;
      2'h3: frac_sixths = 3'h3;
      default: frac_sixths = 3'h0;
    endcase
  endfunction

  // Output P code to ratio 2/4/6/8/16.
  function automatic logic [4:0] p_ratio(input logic [2:0] code);
    case (code)
      3'h1: p_ratio = 5'h04;
      3'h2: p_ratio = 5'h06;
      3'h3: p_ratio = 5'h08;
      3'h4: p_ratio = 5'h10;
      default: p_ratio = 5'h02;
    endcase
  endfunction

  // Output Q and R code to ratio 2/3/4/5/6/8/9.
  function automatic logic [4:0] qr_ratio(input logic [2:0] code);
    case (code)
      3'h1: qr_ratio = 5'h03;
      3'h2: qr_ratio = 5'h04;
      3'h3: qr_ratio = 5'h05;
      3'h4: qr_ratio = 5'h06;
      3'h5: qr_ratio = 5'h08;
      3'h6: qr_ratio = 5'h09;
      default: qr_ratio = 5'h02;
    endcase
  endfunction

endpackage

// *** input_sync.sv ***
// Three-stage synchroniser; the output follows once the last two stages agree.
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire logic [WIDTH-1:0] dataIn,
  output logic [WIDTH-1:0] dataOut
);

  if (WIDTH < 1) begin : g_bad_width
    $error("width must be at least one");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
    logic [WIDTH-1:0] third;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // Stage one feeds only stage two; the output moves once stages two and three agree.
  always_comb begin
    next_st = st;
    next_st.first = dataIn;
    next_st.second = st.first;
    next_st.third = st.second;
    if (st.second == st.third) begin
      next_st.stable = st.third;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  assign dataOut = st.stable;

endmodule // input_sync

// *** ratio_divider.sv ***
// Divides oscillator-stage ticks by a selectable ratio, one pulse per period.
`timescale 1ns/1ps
module ratio_divider #(
  parameter int RATIO_W = 5
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire logic tick,
  input wire logic [RATIO_W-1:0] ratio,
  output logic divPulse
);

  if (RATIO_W < 2) begin : g_bad_width
    $error("ratio width must be at least two");
  end

  typedef struct packed {
    logic [RATIO_W-1:0] count;
    logic pulse;
  } div_s;

  div_s st;
  div_s next_st;

  // Counts ticks and fires on the last tick of each period.
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (tick) begin
      if (st.count >= ratio - RATIO_W'(1)) begin
        next_st.count = '0;
        next_st.pulse = 1'b1;
      end else begin
        next_st.count = st.count + RATIO_W'(1);
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  assign divPulse = st.pulse;

endmodule // ratio_divider

// *** pll_and_fast_onchip_oscillator_clock_config.sv ***
// Registers and control of two multiplying loops and the fast on-chip oscillator.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module pll_and_fast_onchip_oscillator_clock_config (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regReadData,
  input wire logic secureAccess,
  input wire logic clockWriteEnable,
  input wire logic optionFastOscEnable,
  input wire logic [2:0] optionFastOscFreq,
  input wire logic [1:0] vcoTick,
  output logic [1:0] loopSourceSelect,
  output logic [1:0][2:0] loopInputDivide,
  output logic [1:0][10:0] loopFactorSixths,
  output logic [1:0][2:0] outClockPulse,
  output logic sysclkNonsecureAttr,
  output logic fastOscNonsecureAttr,
  output logic fastOscStop,
  output logic [2:0] fastOscFreqCode
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pll_clk_pkg::boot_e boot;
    logic [2:0] settle;
    logic [31:0] readData;
    logic sysclkAttr;
    logic fastOscAttr;
    logic [1:0][15:0] loopCtrl;
    logic [1:0][11:0] outDiv;
    logic oscStop;
    logic [2:0] oscFreq;
    logic refused;
    logic [1:0] srcSel;
    logic [1:0][2:0] inDiv;
    logic [1:0][10:0] factor;
  } state_s;

  localparam state_s STATE_RESET = '{
    boot: pll_clk_pkg::BOOT_SETTLE,
    settle: '0,
    readData: '0,
    sysclkAttr: 1'b0,
    fastOscAttr: 1'b0,
    loopCtrl: {pll_clk_pkg::LOOP_CTRL_RESET, pll_clk_pkg::LOOP_CTRL_RESET},
    outDiv: {pll_clk_pkg::OUT_DIV_RESET, pll_clk_pkg::OUT_DIV_RESET},
    oscStop: 1'b1,
    oscFreq: pll_clk_pkg::OSC_FREQ_RESET,
    refused: 1'b0,
    srcSel: '0,
    inDiv: {3'h1, 3'h1},
    factor: {11'h09c, 11'h09c}
  };

  state_s st;
  state_s next_st;

  logic strapEnable;
  logic [2:0] strapFreq;
  logic [1:0] mulBad;
  logic oscAccess;

  // ----------------------------------------------------------------
  // Option strap synchroniser
  // ----------------------------------------------------------------
  // Option straps are asynchronous, so they pass three stages.
  input_sync #(
    .WIDTH(4)
  ) u_strap_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEnable(clockEnable),
    .dataIn({optionFastOscEnable, optionFastOscFreq}),
    .dataOut({strapEnable, strapFreq})
  );

  // Upper legal multiplier code of a loop.
  function automatic logic [7:0] mul_max(input int loop);
    mul_max = (loop == 0) ? pll_clk_pkg::LOOP_A_MUL_MAX : pll_clk_pkg::LOOP_B_MUL_MAX;
  endfunction

  // Whether a multiplier code is legal for a loop.
  function automatic logic mul_ok(input logic [7:0] code, input int loop);
    mul_ok = (code >= pll_clk_pkg::MUL_MIN) && (code <= mul_max(loop));
  endfunction

  // Flags loops whose multiplier, such as the reset value, is illegal.
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      mulBad[k] = !mul_ok(st.loopCtrl[k][pll_clk_pkg::MUL_LSB +: 8], k);
    end
  end

  // Oscillator registers admit secure masters, or any once marked non-secure.
  assign oscAccess = secureAccess | st.fastOscAttr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Strap load, writes, read capture and derived loop settings.
  always_comb begin
    logic refuseEv;
    logic refuseClr;
    logic [1:0] loopSel;
    logic [1:0] divSel;
    logic [7:0] mulCode;
    logic [11:0] divCode;
    refuseEv = 1'b0;
    refuseClr = 1'b0;
    loopSel = 2'b00;
    divSel = 2'b00;
    mulCode = '0;
    divCode = '0;
    next_st = st;

    // Once the synchronised straps have settled, copy them in.
    case (st.boot)
      pll_clk_pkg::BOOT_SETTLE: begin
        next_st.settle = st.settle + 3'h1;
        if (st.settle == pll_clk_pkg::STRAP_SETTLE) begin
          next_st.boot = pll_clk_pkg::BOOT_RUN;
          next_st.oscStop = strapEnable;
          next_st.oscFreq = strapFreq;
        end
      end
      pll_clk_pkg::BOOT_RUN: begin
        next_st.settle = st.settle;
      end
      default: begin
        next_st.boot = pll_clk_pkg::BOOT_SETTLE;
      end
    endcase

    loopSel[0] = (regAddr == pll_clk_pkg::ADDR_LOOP_A);
    loopSel[1] = (regAddr == pll_clk_pkg::ADDR_LOOP_B);
    divSel[0] = (regAddr == pll_clk_pkg::ADDR_OUT_DIV_A);
    divSel[1] = (regAddr == pll_clk_pkg::ADDR_OUT_DIV_B);
    mulCode = regWriteData[pll_clk_pkg::MUL_LSB +: 8];
    divCode = regWriteData[11:0];

    // Writes; a refused write leaves the register and sets the sticky flag.
    if (regWrite) begin
      for (int k = 0; k < 2; k++) begin
        if (loopSel[k]) begin
          if (mul_ok(mulCode, k)) begin
            next_st.loopCtrl[k] = regWriteData[15:0] & pll_clk_pkg::LOOP_CTRL_MASK;
          end else begin
            refuseEv = 1'b1;
          end
        end
        if (divSel[k]) begin
          if ((divCode[pll_clk_pkg::OUT_P_LSB +: 3] <= pll_clk_pkg::P_CODE_MAX) &&
              (divCode[pll_clk_pkg::OUT_Q_LSB +: 3] <= pll_clk_pkg::QR_CODE_MAX) &&
              (divCode[pll_clk_pkg::OUT_R_LSB +: 3] <= pll_clk_pkg::QR_CODE_MAX)) begin
            next_st.outDiv[k] = divCode & pll_clk_pkg::OUT_DIV_MASK;
          end else begin
            refuseEv = 1'b1;
          end
        end
      end
      case (regAddr)
        pll_clk_pkg::ADDR_SECURITY: begin
          if (secureAccess) begin
            next_st.sysclkAttr = regWriteData[pll_clk_pkg::SEC_SYSCLK_BIT];
            next_st.fastOscAttr = regWriteData[pll_clk_pkg::SEC_FASTOSC_BIT];
          end else begin
            refuseEv = 1'b1;
          end
        end
        pll_clk_pkg::ADDR_OSC_STOP: begin
          if (oscAccess && clockWriteEnable && (st.boot == pll_clk_pkg::BOOT_RUN)) begin
            next_st.oscStop = regWriteData[pll_clk_pkg::OSC_STOP_BIT];
          end else begin
            refuseEv = 1'b1;
          end
        end
        pll_clk_pkg::ADDR_OSC_FREQ: begin
          if (oscAccess && clockWriteEnable && st.oscStop && (st.boot == pll_clk_pkg::BOOT_RUN)) begin
            next_st.oscFreq = regWriteData[pll_clk_pkg::OSC_FREQ_LSB +: 3];
          end else begin
            refuseEv = 1'b1;
          end
        end
        pll_clk_pkg::ADDR_STATUS: begin
          refuseClr = regWriteData[pll_clk_pkg::ST_REFUSED];
        end
        default: begin
          refuseClr = 1'b0;
        end
      endcase
    end

    // A refusal beside a clear keeps the flag set.
    next_st.refused = (st.refused & ~refuseClr) | refuseEv;

    // Read data stand in the next cycle; unused bits and offsets read zero.
    next_st.readData = '0;
    if (regRead) begin
      case (regAddr)
        pll_clk_pkg::ADDR_SECURITY: begin
          next_st.readData[pll_clk_pkg::SEC_SYSCLK_BIT] = st.sysclkAttr;
          next_st.readData[pll_clk_pkg::SEC_FASTOSC_BIT] = st.fastOscAttr;
        end
        pll_clk_pkg::ADDR_LOOP_A: begin
          next_st.readData[15:0] = st.loopCtrl[0];
        end
        pll_clk_pkg::ADDR_LOOP_B: begin
          next_st.readData[15:0] = st.loopCtrl[1];
        end
        pll_clk_pkg::ADDR_OSC_STOP: begin
          next_st.readData[pll_clk_pkg::OSC_STOP_BIT] = st.oscStop & oscAccess;
        end
        pll_clk_pkg::ADDR_OSC_FREQ: begin
          next_st.readData[pll_clk_pkg::OSC_FREQ_LSB +: 3] = oscAccess ? st.oscFreq : 3'h0;
        end
        pll_clk_pkg::ADDR_OUT_DIV_A: begin
          next_st.readData[11:0] = st.outDiv[0];
        end
        pll_clk_pkg::ADDR_OUT_DIV_B: begin
          next_st.readData[11:0] = st.outDiv[1];
        end
        pll_clk_pkg::ADDR_STATUS: begin
          next_st.readData[pll_clk_pkg::ST_REFUSED] = st.refused;
          next_st.readData[pll_clk_pkg::ST_BOOTED] = (st.boot == pll_clk_pkg::BOOT_RUN);
          next_st.readData[pll_clk_pkg::ST_STOPPED] = st.oscStop;
          next_st.readData[pll_clk_pkg::ST_MUL_BAD_A] = mulBad[0];
          next_st.readData[pll_clk_pkg::ST_MUL_BAD_B] = mulBad[1];
        end
        default: begin
          next_st.readData = '0;
        end
      endcase
    end

    // Derived loop settings follow the controls a cycle later.
    for (int k = 0; k < 2; k++) begin
      next_st.srcSel[k] = st.loopCtrl[k][pll_clk_pkg::SRC_BIT];
      next_st.inDiv[k] = pll_clk_pkg::idiv_ratio(st.loopCtrl[k][pll_clk_pkg::IDIV_LSB +: 2]);
      next_st.factor[k] = 11'((({3'h0, st.loopCtrl[k][pll_clk_pkg::MUL_LSB +: 8]} + 11'h001) * 11'h006)
                              + {8'h00, pll_clk_pkg::frac_sixths(st.loopCtrl[k][pll_clk_pkg::FRAC_LSB +: 2])});
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // All control state, frozen while the clock enable is low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= STATE_RESET;
    end else if (clockEnable) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Output dividers
  // ----------------------------------------------------------------
  // Three dividers per loop, P on slot 0 and Q, R on slots 1 and 2.
  for (genvar g = 0; g < 2; g++) begin : g_loop
    for (genvar o = 0; o < 3; o++) begin : g_out
      logic [4:0] ratio;
      if (o == 0) begin : g_p
        assign ratio = pll_clk_pkg::p_ratio(st.outDiv[g][pll_clk_pkg::OUT_P_LSB +: 3]);
      end else begin : g_qr
        assign ratio = pll_clk_pkg::qr_ratio(st.outDiv[g][o * pll_clk_pkg::OUT_Q_LSB +: 3]);
      end
      ratio_divider #(
        .RATIO_W(5)
      ) u_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .clockEnable(clockEnable),
        .tick(vcoTick[g]),
        .ratio(ratio),
        .divPulse(outClockPulse[g][o])
      );
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from state
  // ----------------------------------------------------------------
  assign regReadData = st.readData;
  assign loopSourceSelect = st.srcSel;
  assign loopInputDivide = st.inDiv;
  assign loopFactorSixths = st.factor;
  assign sysclkNonsecureAttr = st.sysclkAttr;
  assign fastOscNonsecureAttr = st.fastOscAttr;
  assign fastOscStop = st.oscStop;
  assign fastOscFreqCode = st.oscFreq;

endmodule // pll_and_fast_onchip_oscillator_clock_config

// *** pll_clk_monitor.sv ***
// Port checks of the clock configuration block.
`timescale 1ns/1ps
module pll_clk_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWrite,
  input wire logic secureAccess,
  input wire logic clockWriteEnable,
  input wire logic optionFastOscEnable,
  input wire logic [2:0] optionFastOscFreq,
  input wire logic [1:0] loopSourceSelect,
  input wire logic [1:0][2:0] loopInputDivide,
  input wire logic [1:0][10:0] loopFactorSixths,
  input wire logic [1:0][2:0] outClockPulse,
  input wire logic sysclkNonsecureAttr,
  input wire logic fastOscNonsecureAttr,
  input wire logic fastOscStop,
  input wire logic [2:0] fastOscFreqCode
);
  // ----------------------------------------------------------------
  // Helpers and write sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Factor in sixths of a loop control word.
  function automatic logic [10:0] sixths(input logic [15:0] w);
    sixths = ({3'h0, w[15:8]} + 11'h1) * 11'h6 + 11'((w[7:6] == 2'h3) ? 3 : 2 * w[7:6]);
  endfunction

  sequence s_a_ok;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_LOOP_A && regWriteData[15:8] inside {[8'h34:8'hb3]};
  endsequence
  sequence s_a_bad;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_LOOP_A && !(regWriteData[15:8] inside {[8'h34:8'hb3]});
  endsequence
  sequence s_b_ok;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_LOOP_B && regWriteData[15:8] inside {[8'h34:8'hd3]};
  endsequence
  sequence s_b_bad;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_LOOP_B && !(regWriteData[15:8] inside {[8'h34:8'hd3]});
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_a_src;
    s_a_ok |-> ##2 loopSourceSelect[0] == $past(regWriteData[4], 2);
  endproperty
  property p_a_div;
    s_a_ok |-> ##2 loopInputDivide[0] == {1'b0, $past(regWriteData[1:0], 2)} + 3'h1;
  endproperty
  property p_a_fac;
    s_a_ok |-> ##2 loopFactorSixths[0] == sixths($past(regWriteData[15:0], 2));
  endproperty
  property p_a_bad;
    s_a_bad |=> ($stable(loopFactorSixths[0]) && $stable(loopSourceSelect[0])) [*2];
  endproperty
  property p_b_ok;
    s_b_ok |-> ##2 loopFactorSixths[1] == sixths($past(regWriteData[15:0], 2)) &&
      loopInputDivide[1] == {1'b0, $past(regWriteData[1:0], 2)} + 3'h1 && loopSourceSelect[1] == $past(regWriteData[4], 2);
  endproperty
  property p_b_bad;
    s_b_bad |=> ($stable(loopFactorSixths[1]) && $stable(loopInputDivide[1])) [*2];
  endproperty
  property p_stop_lock;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_OSC_STOP && !clockWriteEnable |=> $stable(fastOscStop);
  endproperty
  property p_freq_run;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_OSC_FREQ && !fastOscStop |=> $stable(fastOscFreqCode);
  endproperty
  property p_strap;
    $fell(sys_rst) |-> ##6 fastOscStop == optionFastOscEnable && fastOscFreqCode == optionFastOscFreq;
  endproperty
  property p_sec_ns;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_SECURITY && !secureAccess
      |=> $stable(sysclkNonsecureAttr) && $stable(fastOscNonsecureAttr);
  endproperty
  property p_sec_wr;
    clockEnable && regWrite && regAddr == pll_clk_pkg::ADDR_SECURITY && secureAccess
      |=> sysclkNonsecureAttr == $past(regWriteData[0]) && fastOscNonsecureAttr == $past(regWriteData[2]);
  endproperty
  property p_pulse;
    outClockPulse[0][0] |=> !outClockPulse[0][0];
  endproperty

  a_a_src: assert property (p_a_src) else $error("loop A source wrong");
  a_a_div: assert property (p_a_div) else $error("loop A divide wrong");
  a_a_fac: assert property (p_a_fac) else $error("loop A factor wrong");
  a_a_bad: assert property (p_a_bad) else $error("loop A took bad code");
  a_b_ok: assert property (p_b_ok) else $error("loop B outputs wrong");
  a_b_bad: assert property (p_b_bad) else $error("loop B took bad code");
  a_stop_lock: assert property (p_stop_lock) else $error("stop bit unlocked");
  a_freq_run: assert property (p_freq_run) else $error("frequency changed while running");
  a_strap: assert property (p_strap) else $error("straps not loaded");
  a_sec_ns: assert property (p_sec_ns) else $error("non-secure write took effect");
  a_sec_wr: assert property (p_sec_wr) else $error("secure write not stored");
  a_pulse: assert property (p_pulse) else $error("output P pulse too long");
endmodule // pll_clk_monitor

bind pll_and_fast_onchip_oscillator_clock_config pll_clk_monitor u_monitor (.clock(clock), .sys_rst(sys_rst),
  .clockEnable(clockEnable), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .secureAccess(secureAccess), .clockWriteEnable(clockWriteEnable), .optionFastOscEnable(optionFastOscEnable),
  .optionFastOscFreq(optionFastOscFreq), .loopSourceSelect(loopSourceSelect), .loopInputDivide(loopInputDivide),
  .loopFactorSixths(loopFactorSixths), .outClockPulse(outClockPulse), .sysclkNonsecureAttr(sysclkNonsecureAttr),
  .fastOscNonsecureAttr(fastOscNonsecureAttr), .fastOscStop(fastOscStop), .fastOscFreqCode(fastOscFreqCode));

// *** test_pll_and_fast_onchip_oscillator_clock_config.sv ***
// Self-checking bench for the clock configuration block.
`timescale 1ns/1ps
module test_pll_and_fast_onchip_oscillator_clock_config;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWriteData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic secureAccess = 1'b1;
  logic clockWriteEnable = 1'b0;
  logic optionFastOscEnable = 1'b1;
  logic [2:0] optionFastOscFreq = 3'h2;
  logic [1:0] vcoTick = 2'h0;
  logic [31:0] regReadData;
  logic [1:0] loopSourceSelect;
  logic [1:0][2:0] loopInputDivide;
  logic [1:0][10:0] loopFactorSixths;
  logic [1:0][2:0] outClockPulse;
  logic sysclkNonsecureAttr;
  logic fastOscNonsecureAttr;
  logic fastOscStop;
  logic [2:0] fastOscFreqCode;
  int errTotal = 0;
  int nCompared = 0;

  // The 40 MHz system clock.
  always #12.5 clock = ~clock;

  pll_and_fast_onchip_oscillator_clock_config u_dut (.clock(clock), .sys_rst(sys_rst), .clockEnable(1'b1), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .secureAccess(secureAccess), .clockWriteEnable(clockWriteEnable), .optionFastOscEnable(optionFastOscEnable),
    .optionFastOscFreq(optionFastOscFreq), .vcoTick(vcoTick), .loopSourceSelect(loopSourceSelect),
    .loopInputDivide(loopInputDivide), .loopFactorSixths(loopFactorSixths), .outClockPulse(outClockPulse),
    .sysclkNonsecureAttr(sysclkNonsecureAttr), .fastOscNonsecureAttr(fastOscNonsecureAttr),
    .fastOscStop(fastOscStop), .fastOscFreqCode(fastOscFreqCode));

  // ----------------------------------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; returns once derived outputs settle.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // One-cycle read; data stand only in the next cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp);
  endtask

  function automatic logic [10:0] facOf(input logic [7:0] m, input logic [1:0] f);
    facOf = ({3'h0, m} + 11'h1) * 11'h6 + 11'((f == 2'h3) ? 3 : 2 * f);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset(input logic en, input logic [2:0] fr);
    @(posedge clock);
    sys_rst <= 1'b1;
    optionFastOscEnable <= en;
    optionFastOscFreq <= fr;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk(32'(fastOscStop), 32'(en));
    chk(32'(fastOscFreqCode), 32'(fr));
    for (int g = 0; g < 2; g++) begin
      chk(32'(loopFactorSixths[g]), 32'h9c);
      chk(32'(loopInputDivide[g]), 32'h1);
    end
    rd(pll_clk_pkg::ADDR_LOOP_A, 32'h1900);
    rd(pll_clk_pkg::ADDR_LOOP_B, 32'h1900);
    rd(pll_clk_pkg::ADDR_OSC_STOP, 32'(en));
    rd(pll_clk_pkg::ADDR_STATUS, {27'h3, en, 2'h2});
  endtask

  task automatic testLoops();
    logic [7:0] a;
    logic [7:0] m;
    logic [7:0] top;
    logic [15:0] d;
    for (int g = 0; g < 2; g++) begin
      a = g ? pll_clk_pkg::ADDR_LOOP_B : pll_clk_pkg::ADDR_LOOP_A;
      top = g ? 8'hd3 : 8'hb3;
      for (int i = 0; i < 4; i++) begin
        m = 8'h34 + 8'(i * 32);
        d = {m, 2'(i), 1'b1, i[0], 2'h3, 2'(i)};
        wr(a, {16'h0, d});
        chk(32'(loopInputDivide[g]), 32'(i + 1));
        chk(32'(loopSourceSelect[g]), 32'(i[0]));
        chk(32'(loopFactorSixths[g]), 32'(facOf(m, 2'(i))));
        rd(a, {16'h0, d & 16'hffd3});
      end
      wr(a, {16'h0, top, 8'h00});
      chk(32'(loopFactorSixths[g]), 32'(facOf(top, 2'h0)));
      wr(a, {16'h0, top + 8'h1, 8'h00});
      chk(32'(loopFactorSixths[g]), 32'(facOf(top, 2'h0)));
      wr(a, {16'h0, 8'h33, 8'h00});
      rd(a, {16'h0, top, 8'h00});
    end
    rd(pll_clk_pkg::ADDR_STATUS, 32'h7);
  endtask

  task automatic testOsc();
    wr(pll_clk_pkg::ADDR_OSC_STOP, 32'h0);
    chk(32'(fastOscStop), 32'h1);
    clockWriteEnable <= 1'b1;
    wr(pll_clk_pkg::ADDR_OSC_STOP, 32'h0);
    chk(32'(fastOscStop), 32'h0);
    wr(pll_clk_pkg::ADDR_OSC_FREQ, 32'h4);
    chk(32'(fastOscFreqCode), 32'h2);
    wr(pll_clk_pkg::ADDR_OSC_STOP, 32'h1);
    wr(pll_clk_pkg::ADDR_OSC_FREQ, 32'h4);
    chk(32'(fastOscFreqCode), 32'h4);
    rd(pll_clk_pkg::ADDR_OSC_STOP, 32'h1);
    secureAccess <= 1'b0;
    rd(pll_clk_pkg::ADDR_OSC_FREQ, 32'h0);
    wr(pll_clk_pkg::ADDR_SECURITY, 32'h5);
    chk(32'({sysclkNonsecureAttr, fastOscNonsecureAttr}), 32'h0);
    secureAccess <= 1'b1;
    wr(pll_clk_pkg::ADDR_SECURITY, 32'h7);
    chk(32'({sysclkNonsecureAttr, fastOscNonsecureAttr}), 32'h3);
    rd(pll_clk_pkg::ADDR_SECURITY, 32'h5);
    secureAccess <= 1'b0;
    rd(pll_clk_pkg::ADDR_OSC_FREQ, 32'h4);
    rd(8'h20, 32'h0);
    secureAccess <= 1'b1;
  endtask

  // Cycles between output pulses, ticking every cycle; the first two gaps are skipped.
  task automatic gap(input int g, input int o, input int exp);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clock);
        #1;
        n++;
      end while (outClockPulse[g][o] !== 1'b1 && n < 40);
    end
    chk(32'(n), 32'(exp));
  endtask

  task automatic testDiv();
    int pTab[5] = '{2, 4, 6, 8, 16};
    int qTab[7] = '{2, 3, 4, 5, 6, 8, 9};
    int p;
    vcoTick <= 2'h3;
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 7; i++) begin
        p = (i > 4) ? 4 : i;
        wr(g ? pll_clk_pkg::ADDR_OUT_DIV_B : pll_clk_pkg::ADDR_OUT_DIV_A, {21'h0, 3'(6 - i), 1'b0, 3'(i), 1'b0, 3'(p)});
        gap(g, 0, pTab[p]);
        gap(g, 1, qTab[i]);
        gap(g, 2, qTab[6 - i]);
      end
    end
    vcoTick <= 2'h0;
  endtask

  // Prints counts and verdict, then ends the run.
  task automatic reportAndStop();
    $display("compared %0d, wrong %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence, with a second reset under other straps.
  initial begin
    testReset(1'b1, 3'h2);
    testLoops();
    testOsc();
    testDiv();
    testReset(1'b0, 3'h7);
    reportAndStop();
  end

  // Watchdog far beyond the expected run.
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    reportAndStop();
  end
endmodule // test_pll_and_fast_onchip_oscillator_clock_config
